// ---- crc_pkg.sv ----
// Package for the CRC result control block: register map, field layout, carriers and the byte lane decoder.
// Assumes a single 8-bit special function register bus on the system clock.
package crc_pkg;
   localparam int unsigned CRC_SFR_W = 8;
   localparam logic [7:0] CRC_CTRL_ADDR = 8'h92;
   localparam logic [7:0] CRC_DATA_ADDR = 8'h91;
   localparam logic [7:0] CRC_CTRL_RESET = 8'h00;
   localparam int unsigned CRC_SEL_BIT = 4;
   localparam int unsigned CRC_INIT_BIT = 3;
   localparam int unsigned CRC_VAL_BIT = 2;
   localparam int unsigned CRC_PTR_MSB = 1;
   localparam int unsigned CRC_PTR_LSB = 0;
   localparam logic [2:0] CRC_UNUSED_READ = 3'h0;
   localparam logic [15:0] CRC_POLY16 = 16'h1021;
   localparam logic [31:0] CRC_PRESET_ZEROS = 32'h0000_0000;
   localparam logic [31:0] CRC_PRESET_ONES = 32'hffff_ffff;
   localparam logic [1:0] CRC_PTR_STEP = 2'h1;
   localparam logic [1:0] CRC_LANE_LOW = 2'h0;
   localparam logic [1:0] CRC_LANE_HIGH16 = 2'h1;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } crc_sfr_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } crc_feed_s;

   // Maps the byte pointer to a result byte lane for the selected result length.
   function automatic logic [1:0] crc_lane(input logic [1:0] ptr, input logic sel16);
      if (!sel16) begin
         crc_lane = ptr;
      end else if (ptr[0]) begin
         crc_lane = CRC_LANE_HIGH16;
      end else begin
         crc_lane = CRC_LANE_LOW;
      end
   endfunction : crc_lane
endpackage : crc_pkg

// ---- crc_step.sv ----
// Combinational CRC update of one input byte, most significant bit first.
// Assumes the caller registers the result; the upper half is held unchanged in 16-bit mode.
`timescale 1ns/1ps
`default_nettype none
module crc_step #(
   parameter logic [31:0] POLY32 = 32'h0000_0001
) (
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data,
   input wire logic sel16,
   output logic [31:0] crc_out
);
   import crc_pkg::*;

   always_comb begin
      logic [31:0] c32;
      logic [15:0] c16;
      logic fb;
      c32 = crc_in;
      c16 = crc_in[15:0];
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         fb = c32[31] ^ data[i];
         c32 = {c32[30:0], 1'b0} ^ (fb ? POLY32 : CRC_PRESET_ZEROS);
         fb = c16[15] ^ data[i];
         c16 = {c16[14:0], 1'b0} ^ (fb ? CRC_POLY16 : 16'h0000);
      end
      crc_out = sel16 ? {crc_in[31:16], c16} : c32;
   end
endmodule : crc_step
`default_nettype wire

// ---- crc_result_control.sv ----
// CRC result control: control register, result byte pointer, result data port and byte-wise CRC engine.
// Assumes the processor drives one SFR request per cycle on the system clock and the data feed is on that clock.
`timescale 1ns/1ps
`default_nettype none
module crc_result_control #(
   parameter logic [31:0] POLY32 = 32'h0000_0001
) (
   input wire logic clock,
   input wire logic reset,
   input wire crc_pkg::crc_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire crc_pkg::crc_feed_s feed,
   output logic [31:0] crc_result
);
   import crc_pkg::*;

   logic sel16_reg;
   logic preset_ones_reg;
   logic [1:0] ptr_reg;
   logic [31:0] result_reg;
   logic [7:0] rdata_reg;
   logic [31:0] step_out;
   logic ctrl_wr;
   logic ctrl_rd;
   logic data_wr;
   logic data_rd;
   logic data_acc;
   logic init_cmd;
   logic [1:0] lane;
   logic [31:0] preset_val;
   logic [31:0] written_val;
   logic [7:0] ctrl_view;

   assign ctrl_wr = sfr_req.wr && (sfr_req.addr == CRC_CTRL_ADDR);
   assign ctrl_rd = sfr_req.rd && (sfr_req.addr == CRC_CTRL_ADDR);
   assign data_wr = sfr_req.wr && (sfr_req.addr == CRC_DATA_ADDR);
   assign data_rd = sfr_req.rd && (sfr_req.addr == CRC_DATA_ADDR);
   assign data_acc = data_wr || data_rd;
   assign init_cmd = ctrl_wr && sfr_req.wdata[CRC_INIT_BIT];
   assign lane = crc_lane(ptr_reg, sel16_reg);
   assign ctrl_view = {CRC_UNUSED_READ, sel16_reg, 1'b0, preset_ones_reg, ptr_reg};

   // The preset value follows the set-value bit written in the same cycle.
   assign preset_val = sfr_req.wdata[CRC_VAL_BIT] ? CRC_PRESET_ONES : CRC_PRESET_ZEROS;

   always_comb begin
      written_val = result_reg;
      written_val[8*lane +: 8] = sfr_req.wdata;
   end

   crc_step #(
      .POLY32(POLY32)
   ) u_step (
      .crc_in(result_reg),
      .data(feed.data),
      .sel16(sel16_reg),
      .crc_out(step_out)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         sel16_reg <= CRC_CTRL_RESET[CRC_SEL_BIT];
         preset_ones_reg <= CRC_CTRL_RESET[CRC_VAL_BIT];
      end else if (ctrl_wr) begin
         sel16_reg <= sfr_req.wdata[CRC_SEL_BIT];
         preset_ones_reg <= sfr_req.wdata[CRC_VAL_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ptr_reg <= CRC_CTRL_RESET[CRC_PTR_MSB:CRC_PTR_LSB];
      end else if (ctrl_wr) begin
         ptr_reg <= sfr_req.wdata[CRC_PTR_MSB:CRC_PTR_LSB];
      end else if (data_acc) begin
         ptr_reg <= ptr_reg + CRC_PTR_STEP;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         result_reg <= CRC_PRESET_ZEROS;
      end else if (init_cmd) begin
         result_reg <= preset_val;
      end else if (data_wr) begin
         result_reg <= written_val;
      end else if (feed.valid) begin
         result_reg <= step_out;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_reg <= 8'h00;
      end else if (ctrl_rd) begin
         rdata_reg <= ctrl_view;
      end else if (data_rd) begin
         rdata_reg <= result_reg[8*lane +: 8];
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign sfr_rdata = rdata_reg;
   assign crc_result = result_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence s_data_read;
      data_rd && !ctrl_wr;
   endsequence

   sequence s_init_write;
      init_cmd;
   endsequence

   a_unused_read_zero: assert property (ctrl_rd |=> sfr_rdata[7:5] == CRC_UNUSED_READ)
      else $error("Unused control bits did not read zero.");

   a_sel_stored: assert property (ctrl_wr |=> sel16_reg == $past(sfr_req.wdata[CRC_SEL_BIT]))
      else $error("Select bit not stored from the control write.");

   a_poly16_step: assert property (feed.valid && sel16_reg && !init_cmd && !data_wr
      && result_reg[15:0] == 16'h0000 && feed.data == 8'h01 |=> result_reg[15:0] == CRC_POLY16)
      else $error("16-bit step did not apply the generator.");

   a_init_preset: assert property (s_init_write |=> result_reg ==
      ($past(sfr_req.wdata[CRC_VAL_BIT]) ? CRC_PRESET_ONES : CRC_PRESET_ZEROS))
      else $error("Init did not preset the full result.");

   a_preset_ones: assert property (s_init_write ##1 (sel16_reg && preset_ones_reg) |-> result_reg == CRC_PRESET_ONES)
      else $error("Set-value one did not give all ones.");

   a_ptr_advance: assert property (s_data_read |=> ptr_reg == $past(ptr_reg) + CRC_PTR_STEP)
      else $error("Pointer did not advance after a data access.");

   a_ptr_wrap: assert property (data_wr && !ctrl_wr && ptr_reg == 2'h3 |=> ptr_reg == 2'h0)
      else $error("Pointer did not wrap to zero.");

   a_lane32_read: assert property ((s_data_read and !sel16_reg) |=>
      sfr_rdata == $past(result_reg[8*ptr_reg +: 8]))
      else $error("32-bit data port read the wrong byte.");

   a_lane16_low: assert property ((s_data_read and (sel16_reg && ptr_reg == 2'h0)) |=>
      sfr_rdata == $past(result_reg[7:0]))
      else $error("16-bit pointer zero did not read the low byte.");

   a_lane16_high: assert property (data_wr && sel16_reg && ptr_reg == 2'h3 |=>
      result_reg[15:8] == $past(sfr_req.wdata))
      else $error("16-bit pointer three did not write the high byte.");

   sequence s_data_write;
      data_wr && !ctrl_wr;
   endsequence

   a_ptr_write_step: assert property (s_data_write |=> ptr_reg == $past(ptr_reg) + CRC_PTR_STEP)
      else $error("Pointer did not advance after a data port write.");

   a_ptr_load: assert property (ctrl_wr |=> ptr_reg == $past(sfr_req.wdata[CRC_PTR_MSB:CRC_PTR_LSB]))
      else $error("Pointer was not loaded from the control write.");

   a_val_stored: assert property (ctrl_wr |=> preset_ones_reg == $past(sfr_req.wdata[CRC_VAL_BIT]))
      else $error("Set-value bit was not stored from the control write.");

   a_preset_zeros: assert property (s_init_write ##1 !preset_ones_reg |-> result_reg == CRC_PRESET_ZEROS)
      else $error("Set-value zero did not give all zeros.");

   a_read_wrap: assert property ((s_data_read and ptr_reg == 2'h3) |=> ptr_reg == 2'h0)
      else $error("Pointer did not wrap to zero after a read.");

   a_lane16_high_read: assert property ((s_data_read and (sel16_reg && ptr_reg == 2'h3)) |=>
      sfr_rdata == $past(result_reg[15:8]))
      else $error("16-bit pointer three did not read the high byte.");

   a_lane16_mid_read: assert property ((s_data_read and (sel16_reg && ptr_reg == 2'h2)) |=>
      sfr_rdata == $past(result_reg[7:0]))
      else $error("16-bit pointer two did not read the low byte.");

   a_lane16_low_write: assert property ((s_data_write and (sel16_reg && ptr_reg == 2'h0)) |=>
      result_reg[7:0] == $past(sfr_req.wdata))
      else $error("16-bit pointer zero did not write the low byte.");

   for (genvar g = 0; g < $bits(result_reg) / CRC_SFR_W; g++) begin : g_lane32
      a_lane32_write: assert property ((s_data_write and (!sel16_reg && ptr_reg == 2'(g))) |=>
         result_reg[CRC_SFR_W*g +: CRC_SFR_W] == $past(sfr_req.wdata))
         else $error("32-bit data port wrote the wrong byte.");
   end

   a_upper_hold16: assert property (feed.valid && sel16_reg && !init_cmd && !data_wr |=>
      result_reg[31:16] == $past(result_reg[31:16]))
      else $error("16-bit step changed the upper result half.");

   a_step32: assert property (feed.valid && !sel16_reg && !init_cmd && !data_wr
      && result_reg == CRC_PRESET_ZEROS && feed.data == 8'h01 |=> result_reg == POLY32)
      else $error("32-bit step did not apply the generator.");

   a_result_hold: assert property (!feed.valid && !init_cmd && !data_wr |=> result_reg == $past(result_reg))
      else $error("Result changed without a preset, write or step.");

   a_ctrl_init_zero: assert property (ctrl_rd |=> sfr_rdata[CRC_INIT_BIT] == 1'b0)
      else $error("Init bit did not read as zero.");

   a_ctrl_sel_view: assert property (ctrl_rd |=> sfr_rdata[CRC_SEL_BIT] == $past(sel16_reg))
      else $error("Select bit read back wrong.");

   a_ctrl_ptr_view: assert property (ctrl_rd |=> sfr_rdata[CRC_PTR_MSB:CRC_PTR_LSB] == $past(ptr_reg))
      else $error("Pointer field read back wrong.");

   a_rdata_idle: assert property (!ctrl_rd && !data_rd |=> sfr_rdata == 8'h00)
      else $error("Read data did not return to zero.");
endmodule : crc_result_control
`default_nettype wire

// ---- crc_result_control_tb.sv ----
// Self-checking testbench for the CRC result control block.
// Assumes the design package and modules are compiled first; it drives the SFR and feed ports directly.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module crc_result_control_tb;
   import crc_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   crc_sfr_req_s sfr_req = '0;
   crc_feed_s feed = '0;
   logic [7:0] sfr_rdata;
   logic [31:0] crc_result;
   logic [7:0] bytes [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   // Arbitrary 32-bit generator handed to the design so the 32-bit step can be predicted.
   localparam logic [31:0] POLY32_TB = 32'h0000_00a5;

   crc_result_control #(
      .POLY32(POLY32_TB)
   ) dut (
      .clock(clock),
      .reset(reset),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .feed(feed),
      .crc_result(crc_result)
   );

   initial begin
      forever #2 clock = ~clock;
   end

   // Drives one SFR request for exactly one rising edge.
   task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(negedge clock);
      sfr_req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge clock);
      sfr_req = '0;
   endtask : access

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(a, 1'b1, d);
   endtask : wr

   // Presents one input byte to the engine for exactly one rising edge.
   task automatic feed_byte(input logic [7:0] d);
      @(negedge clock);
      feed = '{valid: 1'b1, data: d};
      @(negedge clock);
      feed = '0;
   endtask : feed_byte

   // Reads one register, then checks that the read data falls back to zero.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      access(a, 1'b0, 8'h00);
      `CHK(sfr_rdata, exp)
      @(negedge clock);
      `CHK(sfr_rdata, 8'h00)
   endtask : rd

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // Cuts a hang short.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         end_of_test();
      end
   end

   initial begin
      repeat (8) @(negedge clock);
      reset = 1'b0;
      rd(CRC_CTRL_ADDR, 8'h00);
      wr(CRC_CTRL_ADDR, 8'hff);
      `CHK(crc_result, 32'hffff_ffff)
      rd(CRC_CTRL_ADDR, 8'h17);
      rd(8'h55, 8'h00);
      wr(CRC_CTRL_ADDR, 8'h08);
      `CHK(crc_result, 32'h0000_0000)
      for (int i = 0; i < 4; i++) begin
         wr(CRC_DATA_ADDR, bytes[i]);
      end
      `CHK(crc_result, 32'h4433_2211)
      rd(CRC_CTRL_ADDR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(CRC_DATA_ADDR, bytes[i]);
      end
      wr(CRC_CTRL_ADDR, 8'h13);
      wr(CRC_DATA_ADDR, 8'hbb);
      wr(CRC_DATA_ADDR, 8'hcc);
      `CHK(crc_result, 32'h4433_bbcc)
      rd(CRC_CTRL_ADDR, 8'h11);
      wr(CRC_CTRL_ADDR, 8'h10);
      rd(CRC_DATA_ADDR, 8'hcc);
      rd(CRC_DATA_ADDR, 8'hbb);
      rd(CRC_DATA_ADDR, 8'hcc);
      rd(CRC_DATA_ADDR, 8'hbb);
      rd(CRC_CTRL_ADDR, 8'h10);
      wr(CRC_CTRL_ADDR, 8'h18);
      feed_byte(8'h01);
      `CHK(crc_result, 32'h0000_1021)
      wr(8'h55, 8'hff);
      rd(CRC_CTRL_ADDR, 8'h10);
      wr(CRC_CTRL_ADDR, 8'h1c);
      `CHK(crc_result, 32'hffff_ffff)
      feed_byte(8'h00);
      `CHK(crc_result, 32'hffff_e1f0)
      wr(CRC_CTRL_ADDR, 8'h08);
      feed_byte(8'h01);
      `CHK(crc_result, POLY32_TB)
      wr(CRC_CTRL_ADDR, 8'h1c);
      @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      `CHK(crc_result, 32'h0000_0000)
      rd(CRC_CTRL_ADDR, 8'h00);
      end_of_test();
   end
endmodule : crc_result_control_tb
`undef CHK
`default_nettype wire
